/* File: hdl/tsrt_pkg.sv */
// Package for the slave-reset timer time base: register map, fields, states and carriers.
package tsrt_pkg;

    // ==================================================================
    // Register offsets
    // ==================================================================
    localparam logic [7:0] TSRT_OFF_CTRL = 8'h00; // Control word
    localparam logic [7:0] TSRT_OFF_SLAVE = 8'h08; // Slave mode and trigger select
    localparam logic [7:0] TSRT_OFF_IRQEN = 8'h0c; // Trigger interrupt and DMA enables
    localparam logic [7:0] TSRT_OFF_STAT = 8'h10; // Status flags
    localparam logic [7:0] TSRT_OFF_EVGEN = 8'h14; // Event generation
    localparam logic [7:0] TSRT_OFF_CHCFG = 8'h18; // Channel one input configuration
    localparam logic [7:0] TSRT_OFF_CHPOL = 8'h20; // Channel one polarity
    localparam logic [7:0] TSRT_OFF_COUNT = 8'h24; // Counter value
    localparam logic [7:0] TSRT_OFF_PRESC = 8'h28; // Prescaler preload
    localparam logic [7:0] TSRT_OFF_RELOAD = 8'h2c; // Auto-reload preload

    // ==================================================================
    // Field positions and codes
    // ==================================================================
    localparam int TSRT_B_CEN = 0; // Counter enable
    localparam int TSRT_B_URS = 2; // Update request source
    localparam int TSRT_B_TIE = 6; // Trigger interrupt enable
    localparam int TSRT_B_TDE = 14; // Trigger DMA enable
    localparam int TSRT_B_UIF = 0; // Update flag
    localparam int TSRT_B_TIF = 6; // Trigger flag
    localparam int TSRT_B_UG = 0; // Update generate
    localparam int TSRT_B_CH1_POLARITY = 1; // Channel one polarity
    localparam int TSRT_B_CH1_COMPLEMENT_POLARITY = 3; // Channel one complement polarity
    localparam int TSRT_B_MIRROR = 31; // Update flag mirror in the count word
    localparam int TSRT_SMS_LO = 0; // Slave mode field low bit
    localparam int TSRT_TS_LO = 4; // Trigger select field low bit
    localparam int TSRT_SRC_LO = 0; // Channel one source field low bit
    localparam int TSRT_FLT_LO = 4; // Channel one filter field low bit
    localparam logic [2:0] TSRT_SMS_RESET = 3'h4; // Reset slave mode
    localparam logic [2:0] TSRT_TS_TI1 = 3'h5; // Timer input one as trigger
    localparam logic [1:0] TSRT_SRC_TI1 = 2'h1; // Channel one fed by input one
    localparam logic [3:0] TSRT_FLT_NONE = 4'h0; // No input filter

    // ==================================================================
    // Reset values and constants
    // ==================================================================
    localparam logic [15:0] TSRT_RST_PRESC = 16'h0000;
    localparam logic [15:0] TSRT_RST_RELOAD = 16'hffff;
    localparam logic [15:0] TSRT_ZERO16 = 16'h0000;
    localparam logic [15:0] TSRT_ONE16 = 16'h0001;
    localparam logic [31:0] TSRT_ZERO32 = 32'h0000_0000;

    // ==================================================================
    // Types
    // ==================================================================
    // Trigger path state, one-hot
    typedef enum logic [1:0] {
        TSRT_TRG_IDLE = 2'b01,
        TSRT_TRG_HIGH = 2'b10
    } tsrt_trg_state_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tsrt_bus_req_t;

    // Whole block state
    typedef struct packed {
        logic counter_enable;
        logic update_request_source;
        logic trigger_irq_enable;
        logic trigger_dma_enable;
        logic [2:0] slave_mode_select;
        logic [2:0] ts;
        logic [1:0] src;
        logic [3:0] flt;
        logic pol;
        logic npol;
        logic update_flag;
        logic trigger_flag;
        logic [15:0] cnt;
        logic [15:0] psc_pre;
        logic [15:0] psc_act;
        logic [15:0] psc_cnt;
        logic [15:0] arr_pre;
        logic [15:0] arr_act;
        logic ti_s1;
        logic ti_s2;
        tsrt_trg_state_t trg;
        logic [31:0] rdata;
        logic irq;
        logic dma;
    } tsrt_state_t;

endpackage : tsrt_pkg

/* File: hdl/tsrt_timer.sv */
// Timer time base with reset slave mode driven by timer input one.
// ==================================================================
// How it works
// - Trigger event clears counter and prescaler
// - Update source low: trigger reloads preloaded values
// - Slave mode code 100 selects reset mode
// - Trigger select code 101 picks input one
// - Source 01, polarities zero: rising edge only
// - Filter 0000 means unfiltered; no capture prescaler
// - Counting starts only once enable is set
// - Detected rising edge restarts counter from zero
// - Trigger sets flag; enables raise IRQ, DMA
// - Clear lags edge by resynchroniser latency
// - Count bit 31 mirrors update flag; reserved
// - Count low half is counter value
// - Counter ticks once per prescale plus one
// - Prescaler preload copied on every update
// - Reload preload resets to ffff, feeds active
// - Zero reload value holds counter stopped
// - Update refreshes actives, sets update flag, except software update with source high
// - Update generate bit produces update event
// ==================================================================
//
// Decided for this implementation: the plain strobed port.
module tsrt_timer (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire tsrt_pkg::tsrt_bus_req_t bus_in,
    input wire logic timer_input_one_in,
    output logic [31:0] rdata_out,
    output logic trigger_irq_out,
    output logic trigger_dma_out
);
    import tsrt_pkg::*;

    // ==================================================================
    // State
    // ==================================================================
    tsrt_state_t st_ff; // Registered state
    tsrt_state_t nxt_st; // Next state
    logic trig_edge; // Qualified trigger rising edge
    logic reset_mode; // Reset slave mode selected
    logic upd_sw; // Software update request
    logic upd_evt; // Software or trigger update event this cycle, not overflow
    logic tick; // Prescaler wrap

    // Write decode for one offset
    function automatic logic wr_hit(input tsrt_bus_req_t b, input logic [7:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction : wr_hit

    // ==================================================================
    // Next-state logic
    // ==================================================================
    always_comb begin
        nxt_st = st_ff;
        // Resynchroniser: stage two only reads stage one
        nxt_st.ti_s1 = timer_input_one_in;
        nxt_st.ti_s2 = st_ff.ti_s1;
        // Slave controller decode
        reset_mode = (st_ff.slave_mode_select == TSRT_SMS_RESET) && (st_ff.ts == TSRT_TS_TI1);
        // Edge detect on synchronised input, rising only with zero polarities
        trig_edge = 1'b0;
        case (st_ff.trg)
            TSRT_TRG_IDLE: begin
                if (st_ff.ti_s2) begin
                    nxt_st.trg = TSRT_TRG_HIGH;
                    // Filter code accepted unfiltered; other codes also pass unfiltered
                    trig_edge = reset_mode && (st_ff.src == TSRT_SRC_TI1)
                        && !st_ff.pol && !st_ff.npol;
                end
            end
            TSRT_TRG_HIGH: begin
                if (!st_ff.ti_s2) begin
                    nxt_st.trg = TSRT_TRG_IDLE;
                end
            end
            default: begin
                nxt_st.trg = TSRT_TRG_IDLE;
            end
        endcase
        upd_sw = wr_hit(bus_in, TSRT_OFF_EVGEN) && bus_in.wdata[TSRT_B_UG];
        // Trigger update only when update source is low
        upd_evt = upd_sw || (trig_edge && !st_ff.update_request_source);
        // Prescaler and counter
        tick = 1'b0;
        if (trig_edge || upd_sw) begin
            // Clear both counter and prescaler
            nxt_st.psc_cnt = TSRT_ZERO16;
            nxt_st.cnt = TSRT_ZERO16;
        end else if (st_ff.counter_enable && (st_ff.arr_act != TSRT_ZERO16)) begin
            if (st_ff.psc_cnt >= st_ff.psc_act) begin
                nxt_st.psc_cnt = TSRT_ZERO16;
                tick = 1'b1;
            end else begin
                nxt_st.psc_cnt = st_ff.psc_cnt + TSRT_ONE16;
            end
            if (tick) begin
                if (st_ff.cnt >= st_ff.arr_act) begin
                    nxt_st.cnt = TSRT_ZERO16;
                end else begin
                    nxt_st.cnt = st_ff.cnt + TSRT_ONE16;
                end
            end
        end
        // Overflow update event loads actives too
        if (upd_evt || (tick && (st_ff.cnt >= st_ff.arr_act))) begin
            nxt_st.psc_act = st_ff.psc_pre;
            nxt_st.arr_act = st_ff.arr_pre;
        end
        // Register writes
        if (wr_hit(bus_in, TSRT_OFF_CTRL)) begin
            nxt_st.counter_enable = bus_in.wdata[TSRT_B_CEN];
            nxt_st.update_request_source = bus_in.wdata[TSRT_B_URS];
        end
        if (wr_hit(bus_in, TSRT_OFF_SLAVE)) begin
            nxt_st.slave_mode_select = bus_in.wdata[TSRT_SMS_LO +: 3];
            nxt_st.ts = bus_in.wdata[TSRT_TS_LO +: 3];
        end
        if (wr_hit(bus_in, TSRT_OFF_IRQEN)) begin
            nxt_st.trigger_irq_enable = bus_in.wdata[TSRT_B_TIE];
            nxt_st.trigger_dma_enable = bus_in.wdata[TSRT_B_TDE];
        end
        if (wr_hit(bus_in, TSRT_OFF_CHCFG)) begin
            nxt_st.src = bus_in.wdata[TSRT_SRC_LO +: 2];
            nxt_st.flt = bus_in.wdata[TSRT_FLT_LO +: 4];
        end
        if (wr_hit(bus_in, TSRT_OFF_CHPOL)) begin
            nxt_st.pol = bus_in.wdata[TSRT_B_CH1_POLARITY];
            nxt_st.npol = bus_in.wdata[TSRT_B_CH1_COMPLEMENT_POLARITY];
        end
        if (wr_hit(bus_in, TSRT_OFF_COUNT) && !(trig_edge || upd_sw)) begin
            nxt_st.cnt = bus_in.wdata[15:0];
        end
        if (wr_hit(bus_in, TSRT_OFF_PRESC)) begin
            nxt_st.psc_pre = bus_in.wdata[15:0];
        end
        if (wr_hit(bus_in, TSRT_OFF_RELOAD)) begin
            nxt_st.arr_pre = bus_in.wdata[15:0];
        end
        // Status: write zero clears, hardware set wins
        if (wr_hit(bus_in, TSRT_OFF_STAT)) begin
            nxt_st.update_flag = st_ff.update_flag & bus_in.wdata[TSRT_B_UIF];
            nxt_st.trigger_flag = st_ff.trigger_flag & bus_in.wdata[TSRT_B_TIF];
        end
        // Software update with source high does not flag
        if ((upd_evt && !(upd_sw && st_ff.update_request_source)) || (tick && (st_ff.cnt >= st_ff.arr_act))) begin
            nxt_st.update_flag = 1'b1;
        end
        if (trig_edge) begin
            nxt_st.trigger_flag = 1'b1;
        end
        // Interrupt line follows the trigger flag; DMA request pulses on the trigger edge
        nxt_st.irq = nxt_st.trigger_flag && nxt_st.trigger_irq_enable;
        nxt_st.dma = trig_edge && st_ff.trigger_dma_enable;
        // Read data, one cycle later
        nxt_st.rdata = TSRT_ZERO32;
        if (bus_in.rd) begin
            case (bus_in.addr)
                TSRT_OFF_CTRL: begin
                    nxt_st.rdata[TSRT_B_CEN] = st_ff.counter_enable;
                    nxt_st.rdata[TSRT_B_URS] = st_ff.update_request_source;
                end
                TSRT_OFF_SLAVE: begin
                    nxt_st.rdata[TSRT_SMS_LO +: 3] = st_ff.slave_mode_select;
                    nxt_st.rdata[TSRT_TS_LO +: 3] = st_ff.ts;
                end
                TSRT_OFF_IRQEN: begin
                    nxt_st.rdata[TSRT_B_TIE] = st_ff.trigger_irq_enable;
                    nxt_st.rdata[TSRT_B_TDE] = st_ff.trigger_dma_enable;
                end
                TSRT_OFF_STAT: begin
                    nxt_st.rdata[TSRT_B_UIF] = st_ff.update_flag;
                    nxt_st.rdata[TSRT_B_TIF] = st_ff.trigger_flag;
                end
                TSRT_OFF_CHCFG: begin
                    nxt_st.rdata[TSRT_SRC_LO +: 2] = st_ff.src;
                    nxt_st.rdata[TSRT_FLT_LO +: 4] = st_ff.flt;
                end
                TSRT_OFF_CHPOL: begin
                    nxt_st.rdata[TSRT_B_CH1_POLARITY] = st_ff.pol;
                    nxt_st.rdata[TSRT_B_CH1_COMPLEMENT_POLARITY] = st_ff.npol;
                end
                TSRT_OFF_COUNT: begin
                    nxt_st.rdata[TSRT_B_MIRROR] = st_ff.update_flag;
                    nxt_st.rdata[15:0] = st_ff.cnt;
                end
                TSRT_OFF_PRESC: begin
                    nxt_st.rdata[15:0] = st_ff.psc_pre;
                end
                TSRT_OFF_RELOAD: begin
                    nxt_st.rdata[15:0] = st_ff.arr_pre;
                end
                default: begin
                    nxt_st.rdata = TSRT_ZERO32;
                end
            endcase
        end
    end

    // ==================================================================
    // State register
    // ==================================================================
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_ff <= '0;
            st_ff.trg <= TSRT_TRG_IDLE;
            st_ff.psc_pre <= TSRT_RST_PRESC;
            st_ff.psc_act <= TSRT_RST_PRESC;
            st_ff.arr_pre <= TSRT_RST_RELOAD;
            st_ff.arr_act <= TSRT_RST_RELOAD;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out = st_ff.rdata;
    assign trigger_irq_out = st_ff.irq;
    assign trigger_dma_out = st_ff.dma;

    // ==================================================================
    // Checks
    // ==================================================================
    sequence rise_seen_s;
        reset_mode && st_ff.ti_s2 && !$past(st_ff.ti_s2) && (st_ff.trg == TSRT_TRG_IDLE)
            && (st_ff.src == TSRT_SRC_TI1) && !st_ff.pol && !st_ff.npol;
    endsequence

    trig_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        rise_seen_s ##1 1'b1 |-> (st_ff.cnt == TSRT_ZERO16) && (st_ff.psc_cnt == TSRT_ZERO16)
        || $past(wr_hit(bus_in, TSRT_OFF_COUNT))) else $error("trigger did not clear counter");
    trig_flag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge |=> st_ff.trigger_flag) else $error("trigger flag not set");
    trig_dma_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge && st_ff.trigger_dma_enable |=> trigger_dma_out) else $error("trigger dma missing");
    sync_lag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge |-> $past(timer_input_one_in, 2)) else $error("edge without input");
    urs_load_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge && !st_ff.update_request_source |=> st_ff.arr_act == $past(st_ff.arr_pre)) else
        $error("trigger update did not load reload");
    urs_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge && st_ff.update_request_source && !upd_sw && !tick |=> $stable(st_ff.arr_act)) else
        $error("update despite source high");
    stop_cen_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !st_ff.counter_enable && !trig_edge && !bus_in.wr |=> $stable(st_ff.cnt)) else
        $error("counter moved while disabled");
    stop_zero_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        st_ff.arr_act == TSRT_ZERO16 && !trig_edge && !bus_in.wr |=> $stable(st_ff.cnt)) else
        $error("counter moved with zero reload");
    ug_load_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        upd_sw |=> st_ff.psc_act == $past(st_ff.psc_pre)) else $error("prescaler not loaded");
    mirror_rd_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        bus_in.rd && bus_in.addr == TSRT_OFF_COUNT |=> rdata_out[TSRT_B_MIRROR] == $past(st_ff.update_flag)
        && rdata_out[30:16] == 15'h0000) else $error("count word readback wrong");

    // Pin rise with the detector armed and no register write over the sync stages
    sequence pin_rise_s;
        $rose(timer_input_one_in) && !st_ff.ti_s2 && reset_mode && !bus_in.wr
            && (st_ff.src == TSRT_SRC_TI1) && !st_ff.pol && !st_ff.npol ##1 !bus_in.wr;
    endsequence

    // Overflow step: a prescaler wrap with the counter at the active reload
    sequence wrap_seen_s;
        tick && (st_ff.cnt >= st_ff.arr_act) && !bus_in.wr;
    endsequence

    // Edge is decided two cycles after the pin is sampled high
    sync_walk_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        pin_rise_s |=> trig_edge) else $error("edge not two cycles after pin rise");

    // Counter holds between prescaler wraps
    psc_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        st_ff.counter_enable && !trig_edge && !bus_in.wr && (st_ff.psc_cnt < st_ff.psc_act)
        |=> $stable(st_ff.cnt)) else $error("counter moved between prescaler wraps");

    // Overflow wraps to zero, flags and loads the reload preload
    wrap_flag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        wrap_seen_s |=> (st_ff.cnt == TSRT_ZERO16) && st_ff.update_flag
        && (st_ff.arr_act == $past(st_ff.arr_pre))) else $error("overflow update missing");

    // Software update clears the counter and flags with update source low
    ug_flag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        upd_sw && !st_ff.update_request_source |=> st_ff.update_flag && (st_ff.cnt == TSRT_ZERO16))
        else $error("software update not flagged");

    // Trigger with update source high leaves the update flag alone
    urs_noflag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trig_edge && st_ff.update_request_source && !bus_in.wr |=> $stable(st_ff.update_flag))
        else $error("update flag set by trigger with source high");

    // Interrupt line stands while flag and enable are both set
    irq_level_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        st_ff.trigger_flag && st_ff.trigger_irq_enable |-> trigger_irq_out) else $error("trigger interrupt missing");

    // Trigger DMA request is a single-cycle pulse
    dma_pulse_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        trigger_dma_out |=> !trigger_dma_out) else $error("trigger dma longer than a cycle");

    // Prescaler counter also holds while the reload is zero
    zero_psc_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        st_ff.arr_act == TSRT_ZERO16 && !trig_edge && !bus_in.wr |=> $stable(st_ff.psc_cnt))
        else $error("prescaler moved with zero reload");

    // Read data stand only in the cycle after the read strobe
    rd_once_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !bus_in.rd |=> rdata_out == TSRT_ZERO32) else $error("read data outside read slot");

endmodule : tsrt_timer

/* File: dv/tsrt_trig_src.sv */
// Far-side source that drives timer input one from a level asked for by the bench.
module tsrt_trig_src (
    input wire logic clk_sys_in,
    input wire logic level_in,
    output logic ti1_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Output stage
    // ==================================================================
    // The source changes its pin only just after a clock edge
    initial begin
        ti1_out = 1'b0;
    end
    always @(posedge clk_sys_in) begin
        ti1_out <= level_in;
    end
endmodule : tsrt_trig_src

/* File: dv/tb_top.sv */
// Self-checking bench for the slave-reset timer time base.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tsrt_pkg::*;
    // ==================================================================
    // Signals
    // ==================================================================
    logic clk_sys_in = 1'b0; // System clock
    logic srst_in = 1'b1; // Synchronous reset
    tsrt_bus_req_t bus = '0; // Register request
    logic lvl = 1'b0; // Level asked of the source
    logic ti1; // Timer input one pin
    logic [31:0] rdata; // Read data
    logic irq; // Trigger interrupt
    logic dma; // Trigger DMA pulse
    int error_cnt = 0;
    int tests_run = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    tsrt_trig_src i_tsrt_trig_src (.clk_sys_in(clk_sys_in), .level_in(lvl), .ti1_out(ti1));
    tsrt_timer i_tsrt_timer (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .bus_in(bus),
        .timer_input_one_in(ti1), .rdata_out(rdata), .trigger_irq_out(irq),
        .trigger_dma_out(dma));
    // ==================================================================
    // Shared tasks
    // ==================================================================
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus.wr <= 1'b0;
    endtask : wr
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Rising edge on the input; returns edges until the DMA pulse, 0 if none
    task automatic fire(output int n);
        @(posedge clk_sys_in);
        lvl <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        lvl <= 1'b1;
        n = 0;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clk_sys_in);
            #1 if (dma === 1'b1 && n == 0) n = i;
        end
    endtask : fire
    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_reset();
        logic [31:0] d;
        rd(TSRT_OFF_COUNT, d); chk(d, 32'h0, "count reset");
        rd(TSRT_OFF_PRESC, d); chk(d, 32'h0, "prescale reset");
        rd(TSRT_OFF_RELOAD, d); chk(d, 32'h0000_ffff, "reload reset");
        rd(8'h04, d); chk(d, 32'h0, "unmapped read");
        rd(TSRT_OFF_COUNT, d); chk(d, 32'h0, "count idle");
        $display("test reset done");
    endtask : t_reset
    task automatic t_enable();
        logic [31:0] a, b;
        wr(TSRT_OFF_CTRL, 32'h1);
        rd(TSRT_OFF_COUNT, a);
        rd(TSRT_OFF_COUNT, b);
        chk(b - a, 32'h2, "count step");
        $display("test enable done");
    endtask : t_enable
    task automatic t_trigger();
        logic [31:0] d, p;
        int n;
        wr(TSRT_OFF_CHCFG, 32'h1);
        wr(TSRT_OFF_CHPOL, 32'h0);
        wr(TSRT_OFF_SLAVE, 32'h54);
        wr(TSRT_OFF_IRQEN, 32'h4040);
        wr(TSRT_OFF_PRESC, 32'h1);
        wr(TSRT_OFF_RELOAD, 32'h3);
        wr(TSRT_OFF_STAT, 32'h0);
        fire(n);
        chk(n, 4, "trigger latency");
        chk(irq, 1'b1, "irq raised");
        rd(TSRT_OFF_STAT, d); chk(d, 32'h41, "flags");
        rd(TSRT_OFF_COUNT, p); chk(p[31], 1'b1, "mirror");
        for (int i = 0; i < 6; i++) begin
            rd(TSRT_OFF_COUNT, d);
            chk(d[15:0] <= 16'h3, 1'b1, "reload taken");
            chk((d - p) & 32'h3, 32'h1, "prescale taken");
            p = d;
        end
        wr(TSRT_OFF_STAT, 32'h0);
        #1 chk(irq, 1'b0, "irq cleared");
        rd(TSRT_OFF_COUNT, d); chk(d[31], 1'b0, "mirror clear");
        $display("test trigger done");
    endtask : t_trigger
    task automatic t_no_update();
        logic [31:0] d;
        logic seen;
        int n;
        // Counter stopped so that no overflow loads the new reload early
        wr(TSRT_OFF_CTRL, 32'h4);
        wr(TSRT_OFF_RELOAD, 32'h2);
        wr(TSRT_OFF_STAT, 32'h0);
        fire(n);
        chk(n, 4, "clear latency");
        rd(TSRT_OFF_STAT, d); chk(d, 32'h40, "no update flag");
        rd(TSRT_OFF_COUNT, d); chk(d, 32'h0, "cleared while stopped");
        wr(TSRT_OFF_CTRL, 32'h5);
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(TSRT_OFF_COUNT, d);
            if (d[15:0] == 16'h3) seen = 1'b1;
        end
        chk(seen, 1'b1, "old reload kept");
        $display("test no update done");
    endtask : t_no_update
    task automatic t_ignored();
        logic [31:0] cfg [5] = '{32'h50, 32'h44, 32'h54, 32'h54, 32'h54};
        logic [31:0] pol [5] = '{32'h0, 32'h0, 32'h2, 32'h8, 32'h0};
        logic [31:0] src [5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h2};
        logic [31:0] d;
        int n;
        for (int k = 0; k < 5; k++) begin
            wr(TSRT_OFF_SLAVE, cfg[k]);
            wr(TSRT_OFF_CHPOL, pol[k]);
            wr(TSRT_OFF_CHCFG, src[k]);
            wr(TSRT_OFF_STAT, 32'h0);
            fire(n);
            chk(n, 0, "no trigger");
            rd(TSRT_OFF_STAT, d); chk(d[6], 1'b0, "no flag");
        end
        wr(TSRT_OFF_CHPOL, 32'h0);
        wr(TSRT_OFF_CHCFG, 32'h1);
        @(posedge clk_sys_in);
        lvl <= 1'b0;
        n = 0;
        repeat (8) begin
            @(posedge clk_sys_in);
            #1 if (dma === 1'b1) n++;
        end
        chk(n, 0, "falling edge");
        $display("test ignored done");
    endtask : t_ignored
    task automatic t_stop();
        logic [31:0] d;
        wr(TSRT_OFF_CTRL, 32'h1);
        wr(TSRT_OFF_RELOAD, 32'h0);
        wr(TSRT_OFF_EVGEN, 32'h1);
        repeat (4) @(posedge clk_sys_in);
        rd(TSRT_OFF_COUNT, d); chk(d[15:0], 16'h0, "stopped");
        rd(TSRT_OFF_COUNT, d); chk(d[15:0], 16'h0, "still stopped");
        // A running counter would wrap on every tick and flag an update
        wr(TSRT_OFF_STAT, 32'h0);
        repeat (4) @(posedge clk_sys_in);
        rd(TSRT_OFF_STAT, d); chk(d[0], 1'b0, "no wrap while stopped");
        $display("test stop done");
    endtask : t_stop
    // ==================================================================
    // Verdict and main sequence
    // ==================================================================
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        final_report();
    end
    // Reset for six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        t_reset();
        t_enable();
        t_trigger();
        t_no_update();
        t_ignored();
        t_stop();
        final_report();
    end
endmodule : tb_top
